// ### hw/ssm_state_machine.sv
/*
  Slave state machine with transition checks, traffic gating, input snapshot
  and output drive, plus the distributed-clock local time.
  Assumes the master presents one requested state at a time and holds
  request_valid for one cycle; check inputs come from the controller.
*/
`timescale 1ns/1ps
module ssm_state_machine (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // State requests from the master.
  input  wire logic        request_valid,
  input  wire logic [4:0]  request_state,
  // Configuration checks from the controller.
  input  wire logic [3:0]  channel_ok,
  input  wire logic        mapping_ok,
  input  wire logic        dc_used,
  input  wire logic        dc_ok,
  input  wire logic        watchdog_enable,
  // Mailbox and process-data requests.
  input  wire logic        mbx_valid,
  input  wire logic [3:0]  mbx_protocol,
  input  wire logic        pd_valid,
  // Process data.
  input  wire logic [31:0] input_data,
  input  wire logic [31:0] master_output_data,
  // Local time correction.
  input  wire logic        time_load,
  input  wire logic [63:0] time_value,
  // Answers and status.
  output logic             ack,
  output logic             refuse,
  output logic [4:0]       current_state,
  output logic             mbx_accept,
  output logic             pd_accept,
  output logic             snapshot_write,
  output logic [31:0]      snapshot_data,
  output logic [31:0]      output_drive,
  output logic [63:0]      local_time,
  output logic [31:0]      local_time_short
);

  typedef struct packed {
    ssm_pkg::ssm_state_t state;
    logic                ack;
    logic                refuse;
    logic                snap_we;
    logic [31:0]         snap;
    logic [31:0]         outs;
  } ssm_reg_t;

  ssm_reg_t r;
  ssm_reg_t next_r;
  logic     mbx_ok;
  logic     pd_ok;
  logic     go;

  // Mailbox channels are the low pair; process channels start at two.
  assign mbx_ok = &channel_ok[ssm_pkg::MBX_CHANNELS-1:0];
  assign pd_ok  = &channel_ok[ssm_pkg::NUM_CHANNELS-1:ssm_pkg::PD_FIRST_CH] && mapping_ok
                  && (!dc_used || dc_ok);

  // Transition decision, snapshot and output drive. Requests for the current
  // state, or for startup from anywhere, are always acknowledged.
  always_comb begin
    next_r         = r;
    next_r.ack     = 1'b0;
    next_r.refuse  = 1'b0;
    next_r.snap_we = 1'b0;
    go             = 1'b0;
    if (request_valid) begin
      unique case (r.state)
        ssm_pkg::ST_STARTUP: begin
          if (request_state == ssm_pkg::ST_PREPARE) go = mbx_ok;
          else if (request_state == ssm_pkg::ST_FWUPDATE) go = 1'b1;
          else go = (request_state == ssm_pkg::ST_STARTUP);
        end
        ssm_pkg::ST_PREPARE: begin
          if (request_state == ssm_pkg::ST_GUARDED) go = pd_ok;
          else go = (request_state == ssm_pkg::ST_STARTUP)
                    || (request_state == ssm_pkg::ST_PREPARE);
        end
        ssm_pkg::ST_GUARDED: begin
          // Running is the bring-up goal; valid outputs are the master's duty.
          go = (request_state == ssm_pkg::ST_RUNNING)
               || (request_state == ssm_pkg::ST_PREPARE)
               || (request_state == ssm_pkg::ST_STARTUP)
               || (request_state == ssm_pkg::ST_GUARDED);
        end
        ssm_pkg::ST_RUNNING: begin
          go = (request_state != ssm_pkg::ST_FWUPDATE) && (request_state != 5'h00)
               && $onehot(request_state);
        end
        ssm_pkg::ST_FWUPDATE: begin
          go = (request_state == ssm_pkg::ST_STARTUP)
               || (request_state == ssm_pkg::ST_FWUPDATE);
        end
        default: go = 1'b0;
      endcase
      if (go) begin
        next_r.state = ssm_pkg::ssm_state_t'(request_state);
        next_r.ack   = 1'b1;
      end else begin
        next_r.refuse = 1'b1;
      end
      // Inputs are captured in the same cycle the guarded acknowledge rises.
      if (go && request_state == ssm_pkg::ST_GUARDED && r.state == ssm_pkg::ST_PREPARE) begin
        next_r.snap    = input_data;
        next_r.snap_we = 1'b1;
      end
    end
    // Cyclic input refresh while process data runs.
    if (r.state == ssm_pkg::ST_GUARDED || r.state == ssm_pkg::ST_RUNNING) begin
      next_r.snap    = input_data;
      next_r.snap_we = 1'b1;
    end
    // Outputs follow the master only in running, or guarded with no watchdog.
    if (r.state == ssm_pkg::ST_RUNNING) begin
      next_r.outs = master_output_data;
    end else if (r.state == ssm_pkg::ST_GUARDED && !watchdog_enable) begin
      next_r.outs = master_output_data;
    end else begin
      next_r.outs = ssm_pkg::SAFE_OUTPUTS;
    end
  end

  // State register; reset lands in startup with safe outputs.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r.state   <= ssm_pkg::ST_STARTUP;
      r.ack     <= 1'b0;
      r.refuse  <= 1'b0;
      r.snap_we <= 1'b0;
      r.snap    <= 32'h0;
      r.outs    <= ssm_pkg::SAFE_OUTPUTS;
    end else begin
      r <= next_r;
    end
  end

  // Traffic gating is combinational so a request is answered in its cycle.
  always_comb begin
    mbx_accept = 1'b0;
    pd_accept  = 1'b0;
    unique case (r.state)
      ssm_pkg::ST_STARTUP: begin
        mbx_accept = 1'b0;
        pd_accept  = 1'b0;
      end
      ssm_pkg::ST_PREPARE: begin
        mbx_accept = mbx_valid;
        pd_accept  = 1'b0;
      end
      ssm_pkg::ST_GUARDED, ssm_pkg::ST_RUNNING: begin
        mbx_accept = mbx_valid;
        pd_accept  = pd_valid;
      end
      ssm_pkg::ST_FWUPDATE: begin
        mbx_accept = mbx_valid && (mbx_protocol == ssm_pkg::MBX_FILE_XFER);
        pd_accept  = 1'b0;
      end
      default: begin
        mbx_accept = 1'b0;
        pd_accept  = 1'b0;
      end
    endcase
  end

  assign ack            = r.ack;
  assign refuse         = r.refuse;
  assign current_state  = r.state;
  assign snapshot_write = r.snap_we;
  assign snapshot_data  = r.snap;
  assign output_drive   = r.outs;

  ssm_local_time u_time (
    .clk_sys          (clk_sys),
    .resetn           (resetn),
    .time_load        (time_load),
    .time_value       (time_value),
    .local_time       (local_time),
    .local_time_short (local_time_short)
  );

  property p_startup_block;
    @(posedge clk_sys) disable iff (!resetn)
      current_state == ssm_pkg::ST_STARTUP |-> !mbx_accept && !pd_accept;
  endproperty
  a_startup_block: assert property (p_startup_block) else $error("startup traffic");

  property p_prep_check;
    @(posedge clk_sys) disable iff (!resetn)
      request_valid && current_state == ssm_pkg::ST_STARTUP
      && request_state == ssm_pkg::ST_PREPARE && !mbx_ok
      |=> current_state == ssm_pkg::ST_STARTUP && refuse;
  endproperty
  a_prep_check: assert property (p_prep_check) else $error("bad mailbox accepted");

  property p_prep_pd;
    @(posedge clk_sys) disable iff (!resetn)
      current_state == ssm_pkg::ST_PREPARE |-> !pd_accept && (mbx_accept == mbx_valid);
  endproperty
  a_prep_pd: assert property (p_prep_pd) else $error("preparation gating");

  property p_guard_check;
    @(posedge clk_sys) disable iff (!resetn)
      request_valid && current_state == ssm_pkg::ST_PREPARE
      && request_state == ssm_pkg::ST_GUARDED && !pd_ok
      |=> current_state == ssm_pkg::ST_PREPARE;
  endproperty
  a_guard_check: assert property (p_guard_check) else $error("bad channels accepted");

  property p_snapshot;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(current_state == ssm_pkg::ST_GUARDED) && $past(current_state) == ssm_pkg::ST_PREPARE
      |-> ack && snapshot_write && snapshot_data == $past(input_data);
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("no input snapshot");

  property p_safe_out;
    @(posedge clk_sys) disable iff (!resetn)
      current_state == ssm_pkg::ST_GUARDED && watchdog_enable
      ##1 current_state == ssm_pkg::ST_GUARDED |-> output_drive == ssm_pkg::SAFE_OUTPUTS;
  endproperty
  a_safe_out: assert property (p_safe_out) else $error("outputs not safe");

  property p_run_out;
    @(posedge clk_sys) disable iff (!resetn)
      current_state == ssm_pkg::ST_RUNNING |=> output_drive == $past(master_output_data);
  endproperty
  a_run_out: assert property (p_run_out) else $error("outputs not driven");

  property p_fw_entry;
    @(posedge clk_sys) disable iff (!resetn)
      $rose(current_state == ssm_pkg::ST_FWUPDATE) |-> $past(current_state) == ssm_pkg::ST_STARTUP;
  endproperty
  a_fw_entry: assert property (p_fw_entry) else $error("firmware entry illegal");

  property p_fw_mbx;
    @(posedge clk_sys) disable iff (!resetn)
      current_state == ssm_pkg::ST_FWUPDATE && mbx_protocol != ssm_pkg::MBX_FILE_XFER
      |-> !mbx_accept && !pd_accept;
  endproperty
  a_fw_mbx: assert property (p_fw_mbx) else $error("firmware traffic leak");

  property p_refuse_hold;
    @(posedge clk_sys) disable iff (!resetn)
      refuse |-> !ack && current_state == $past(current_state);
  endproperty
  a_refuse_hold: assert property (p_refuse_hold) else $error("refused but moved");

endmodule // ssm_state_machine

// ### hw/ssm_pkg.sv
/*
  Package for the slave state machine block: state codes, mailbox protocol
  codes and distributed-clock time constants.
  Assumes a single 200 MHz device clock shared by every user of the package.
*/
package ssm_pkg;

  // Clock period in picoseconds and local time step per cycle in nanoseconds.
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned TIME_UNIT_PS  = 1000;
  localparam logic [63:0] TIME_STEP_NS  = 64'(CLK_PERIOD_PS / TIME_UNIT_PS);

  // Local time value at reset: zero stands for 2000-01-01 00:00.
  localparam logic [63:0] TIME_EPOCH    = 64'h0;

  // Width of the short local time kept by a reduced device.
  localparam int unsigned SHORT_TIME_W  = 32;

  // Mailbox protocol code of the file-transfer protocol.
  localparam logic [3:0]  MBX_FILE_XFER = 4'h4;

  // Safe output value forced while outputs are not released.
  localparam logic [31:0] SAFE_OUTPUTS  = 32'h0;

  // Number of mailbox channels, first process-data channel and total channels.
  localparam int unsigned MBX_CHANNELS  = 2;
  localparam int unsigned PD_FIRST_CH   = 2;
  localparam int unsigned NUM_CHANNELS  = 4;

  // One-hot state codes of the slave state machine.
  typedef enum logic [4:0] {
    ST_STARTUP  = 5'h01,
    ST_PREPARE  = 5'h02,
    ST_GUARDED  = 5'h04,
    ST_RUNNING  = 5'h08,
    ST_FWUPDATE = 5'h10
  } ssm_state_t;

endpackage

// ### hw/ssm_local_time.sv
/*
  Distributed-clock local time counter, 64 bit, one count per nanosecond.
  Assumes the master writes corrections through the load port.
*/
`timescale 1ns/1ps
module ssm_local_time (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Correction from the master.
  input  wire logic        time_load,
  input  wire logic [63:0] time_value,
  // Current time.
  output logic      [63:0] local_time,
  output logic      [31:0] local_time_short
);

  typedef struct packed {
    logic [63:0] count;
  } ssm_lt_reg_t;

  ssm_lt_reg_t r;
  ssm_lt_reg_t next_r;

  // Advance by the nanoseconds per clock; the master's load overrides the step.
  always_comb begin
    next_r = r;
    if (time_load) begin
      next_r.count = time_value;
    end else begin
      next_r.count = r.count + ssm_pkg::TIME_STEP_NS;
    end
  end

  // Reset places time at the epoch.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r.count <= ssm_pkg::TIME_EPOCH;
    end else begin
      r <= next_r;
    end
  end

  assign local_time       = r.count;
  // The short view simply wraps on its own after about 4.3 s.
  assign local_time_short = r.count[ssm_pkg::SHORT_TIME_W-1:0];

  property p_time_step;
    @(posedge clk_sys) disable iff (!resetn)
      !time_load |=> local_time == $past(local_time) + ssm_pkg::TIME_STEP_NS;
  endproperty
  a_time_step: assert property (p_time_step) else $error("local time step wrong");

endmodule // ssm_local_time

// ### test/ssm_master_model.sv
/*
  Master-side model: state requests, channel and mapping setup, output data
  and local time corrections, each driven just after a falling edge.
  Assumes the bench calls its tasks one at a time and drives the rest.
*/
`timescale 1ns/1ps
module ssm_master_model (
  // Clock.
  input  wire logic        clk_sys,
  // Answers from the device.
  input  wire logic        ack,
  input  wire logic        refuse,
  // Requests and configuration.
  output logic             request_valid,
  output logic [4:0]       request_state,
  output logic [3:0]       channel_ok,
  output logic             mapping_ok,
  output logic             dc_used,
  output logic             dc_ok,
  output logic [31:0]      master_output_data,
  output logic             time_load,
  output logic [63:0]      time_value
);
  // Nothing is configured at power-up, so early requests meet a bare device.
  initial begin
    request_valid = 1'b0;
    request_state = 5'h01;
    {channel_ok, mapping_ok, dc_used, dc_ok} = 7'h00;
    master_output_data = 32'h0;
    time_load = 1'b0;
    time_value = 64'h0;
  end

  // A one-cycle request; the answer is taken one cycle after it.
  task automatic request(input logic [4:0] st, output logic a, output logic r);
    @(negedge clk_sys);
    request_valid = 1'b1;
    request_state = st;
    @(negedge clk_sys);
    a = ack;
    r = refuse;
    request_valid = 1'b0;
    request_state = ~st;
  endtask

  // Mailbox channels, process channels from two, mapping and clock settings.
  task automatic configure(input logic [3:0] ch, input logic mp, input logic du,
                           input logic dk);
    @(negedge clk_sys);
    channel_ok = ch;
    mapping_ok = mp;
    dc_used = du;
    dc_ok = dk;
  endtask

  // Valid output data is placed before any move to the running state.
  task automatic set_outputs(input logic [31:0] d);
    @(negedge clk_sys);
    master_output_data = d;
  endtask

  // A time correction keeps the device aligned with the reference clock.
  task automatic load_time(input logic [63:0] v);
    @(negedge clk_sys);
    time_load = 1'b1;
    time_value = v;
    @(negedge clk_sys);
    time_load = 1'b0;
    time_value = ~v;
  endtask
endmodule // ssm_master_model

// ### test/tb_ssm_state_machine.sv
/*
  Self-checking bench for the slave state machine: bring-up ladder, refused
  moves, traffic gating, input snapshot, output drive and local time.
  Assumes the master model supplies requests and configuration.
*/
`timescale 1ns/1ps
module tb_ssm_state_machine;
  logic        clk_sys, resetn, request_valid, mapping_ok, dc_used, dc_ok;
  logic        watchdog_enable, mbx_valid, pd_valid, time_load;
  logic        ack, refuse, mbx_accept, pd_accept, snapshot_write;
  logic [3:0]  channel_ok, mbx_protocol;
  logic [4:0]  request_state, current_state;
  logic [31:0] input_data, master_output_data, snapshot_data, output_drive;
  logic [31:0] local_time_short;
  logic [63:0] time_value, local_time;
  int          n_checks, miscompares;

  ssm_state_machine dut (.clk_sys(clk_sys), .resetn(resetn),
    .request_valid(request_valid), .request_state(request_state),
    .channel_ok(channel_ok), .mapping_ok(mapping_ok), .dc_used(dc_used),
    .dc_ok(dc_ok), .watchdog_enable(watchdog_enable), .mbx_valid(mbx_valid),
    .mbx_protocol(mbx_protocol), .pd_valid(pd_valid), .input_data(input_data),
    .master_output_data(master_output_data), .time_load(time_load),
    .time_value(time_value), .ack(ack), .refuse(refuse),
    .current_state(current_state), .mbx_accept(mbx_accept),
    .pd_accept(pd_accept), .snapshot_write(snapshot_write),
    .snapshot_data(snapshot_data), .output_drive(output_drive),
    .local_time(local_time), .local_time_short(local_time_short));

  ssm_master_model m (.clk_sys(clk_sys), .ack(ack), .refuse(refuse),
    .request_valid(request_valid), .request_state(request_state),
    .channel_ok(channel_ok), .mapping_ok(mapping_ok), .dc_used(dc_used),
    .dc_ok(dc_ok), .master_output_data(master_output_data),
    .time_load(time_load), .time_value(time_value));

  // A 5 ns clock.
  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  // One request, judged on ack, refuse and the state shown afterwards.
  task automatic req(input logic [4:0] st, input logic ok, input logic [4:0] nx);
    logic a, r;
    m.request(st, a, r);
    chk(a, ok);
    chk(r, !ok);
    chk(current_state, nx);
  endtask

  // Gating is combinational, so it is judged 1 ns into the same cycle.
  task automatic gate(input logic mv, input logic [3:0] pr, input logic pv,
                      input logic em, input logic ep);
    @(negedge clk_sys);
    mbx_valid = mv;
    mbx_protocol = pr;
    pd_valid = pv;
    #1;
    chk(mbx_accept, em);
    chk(pd_accept, ep);
  endtask

  task automatic t_startup();
    chk(current_state, ssm_pkg::ST_STARTUP);
    gate(1'b1, 4'h1, 1'b1, 1'b0, 1'b0);
    gate(1'b1, ssm_pkg::MBX_FILE_XFER, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic t_fwupdate();
    req(ssm_pkg::ST_FWUPDATE, 1'b1, ssm_pkg::ST_FWUPDATE);
    gate(1'b1, ssm_pkg::MBX_FILE_XFER, 1'b1, 1'b1, 1'b0);
    gate(1'b1, 4'h3, 1'b0, 1'b0, 1'b0);
    req(ssm_pkg::ST_STARTUP, 1'b1, ssm_pkg::ST_STARTUP);
  endtask

  task automatic t_prepare();
    m.configure(4'h1, 1'b0, 1'b0, 1'b0);
    req(ssm_pkg::ST_PREPARE, 1'b0, ssm_pkg::ST_STARTUP);
    req(ssm_pkg::ST_GUARDED, 1'b0, ssm_pkg::ST_STARTUP);
    m.configure(4'h3, 1'b0, 1'b0, 1'b0);
    req(ssm_pkg::ST_PREPARE, 1'b1, ssm_pkg::ST_PREPARE);
    gate(1'b1, 4'h1, 1'b1, 1'b1, 1'b0);
    req(ssm_pkg::ST_FWUPDATE, 1'b0, ssm_pkg::ST_PREPARE);
    req(ssm_pkg::ST_RUNNING, 1'b0, ssm_pkg::ST_PREPARE);
  endtask

  task automatic t_guarded();
    input_data = 32'hA5C3_0F96;
    m.configure(4'h7, 1'b1, 1'b0, 1'b0);
    req(ssm_pkg::ST_GUARDED, 1'b0, ssm_pkg::ST_PREPARE);
    m.configure(4'hF, 1'b0, 1'b0, 1'b0);
    req(ssm_pkg::ST_GUARDED, 1'b0, ssm_pkg::ST_PREPARE);
    m.configure(4'hF, 1'b1, 1'b1, 1'b0);
    req(ssm_pkg::ST_GUARDED, 1'b0, ssm_pkg::ST_PREPARE);
    m.configure(4'hF, 1'b1, 1'b1, 1'b1);
    req(ssm_pkg::ST_GUARDED, 1'b1, ssm_pkg::ST_GUARDED);
    chk(snapshot_write, 1'b1);
    chk(snapshot_data, 32'hA5C3_0F96);
    gate(1'b1, 4'h1, 1'b1, 1'b1, 1'b1);
    m.set_outputs(32'h1234_5678);
    // The new input word lands on the falling edge that set_outputs returns on.
    input_data = 32'h3C5A_7E18;
    repeat (2) @(negedge clk_sys);
    chk(snapshot_data, 32'h3C5A_7E18);
    chk(output_drive, ssm_pkg::SAFE_OUTPUTS);
    watchdog_enable = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(output_drive, 32'h1234_5678);
    watchdog_enable = 1'b1;
  endtask

  task automatic t_running();
    m.set_outputs(32'h8E71_3C2B);
    req(ssm_pkg::ST_RUNNING, 1'b1, ssm_pkg::ST_RUNNING);
    @(negedge clk_sys);
    chk(output_drive, 32'h8E71_3C2B);
    gate(1'b1, 4'h1, 1'b1, 1'b1, 1'b1);
    req(ssm_pkg::ST_FWUPDATE, 1'b0, ssm_pkg::ST_RUNNING);
  endtask

  // The load lands near the 32-bit boundary so the short copy wraps.
  task automatic t_time();
    m.load_time(64'h0000_0001_FFFF_FFFE);
    chk(local_time, 64'h0000_0001_FFFF_FFFE);
    @(negedge clk_sys);
    chk(local_time, 64'h0000_0002_0000_0003);
    chk(local_time_short, 32'h0000_0003);
  endtask

  // A second reset in mid-run returns to startup and the epoch.
  task automatic t_reset();
    @(negedge clk_sys);
    resetn = 1'b0;
    #1;
    chk(current_state, ssm_pkg::ST_STARTUP);
    chk(local_time, ssm_pkg::TIME_EPOCH);
    chk(output_drive, ssm_pkg::SAFE_OUTPUTS);
    @(negedge clk_sys);
    resetn = 1'b1;
  endtask

  // Main sequence: reset for 5 cycles, then each scenario in turn.
  initial begin
    resetn = 1'b0;
    watchdog_enable = 1'b1;
    {mbx_valid, pd_valid} = 2'h0;
    mbx_protocol = 4'h0;
    input_data = 32'h0;
    repeat (5) @(negedge clk_sys);
    chk(local_time, ssm_pkg::TIME_EPOCH);
    resetn = 1'b1;
    t_startup();
    t_fwupdate();
    t_prepare();
    t_guarded();
    t_running();
    t_time();
    t_reset();
    t_startup();
    print_verdict();
  end

  // A hang is cut short after a bounded number of cycles.
  initial begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    print_verdict();
  end
endmodule // tb_ssm_state_machine
